/* common/pkhc_pkg.sv */
// Package for the peak hold signal conditioner.
// Assumes a 200 MHz mclk and an APB master with 32-bit data.
package pkhc_pkg;
	// Timing
	localparam longint CLK_PERIOD_PS = 5000;
	localparam longint TICK_TIME_MS = 10;
	localparam longint TICK_CYC_L = TICK_TIME_MS * 1000000000 / CLK_PERIOD_PS;
	localparam int TICK_CYC = int'(TICK_CYC_L);
	localparam logic [6:0] LED_PERIOD_TICKS = 7'h64;
	localparam logic [6:0] LED_DARK_TICKS = 7'h14;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LEVELS = 8'h04;
	localparam logic [7:0] OFF_EMIS = 8'h08;
	localparam logic [7:0] OFF_SUB_RM = 8'h0c;
	localparam logic [7:0] OFF_SUB_MONO = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	// Modes and clear settings
	localparam logic [1:0] MODE_RATIO = 2'h0;
	localparam logic [1:0] MODE_MONO = 2'h1;
	localparam logic [1:0] MODE_METAL = 2'h2;
	localparam logic [3:0] CLR_OFF = 4'h0;
	localparam logic [3:0] CLR_T_LAST = 4'h6;
	localparam logic [3:0] CLR_EXTERN = 4'h7;
	localparam logic [3:0] CLR_AUTO = 4'h8;
	localparam logic [3:0] CLR_HOLD = 4'h9;
	// Clear intervals in ticks: 0.01, 0.05, 0.25, 1.0, 5.0, 25.0 s
	localparam logic [11:0] CLR_TICKS [1:6] = '{12'h001, 12'h005, 12'h019,
		12'h064, 12'h1f4, 12'h9c4};
	// Levels in percent, emissivity and slope in per mille
	localparam logic [6:0] SWOFF_MIN = 7'h02;
	localparam logic [6:0] SWOFF_MAX = 7'h32;
	localparam logic [6:0] SWOFF_RST = 7'h0a;
	localparam logic [6:0] WARN_MAX = 7'h63;
	localparam logic [9:0] UNITY = 10'h3e8;
	localparam logic [15:0] SPAN_MIN = 16'h0032;
	localparam logic [15:0] AUTO_STEP_MIN = 16'h0002;
	// Output codes in microamps
	localparam logic [15:0] UA_FULL = 16'h4e20;
	localparam logic [15:0] UA_LIVE0 = 16'h0fa0;
	localparam logic [15:0] UA_BELOW = 16'h0f3c;
	localparam logic [15:0] UA_LOW21 = 16'h5208;
	// Field positions of CTRL
	localparam int F_MODE = 0;
	localparam int F_LIVE0 = 4;
	localparam int F_LOW21 = 5;
	localparam int F_CLR = 8;
	localparam int F_SMOOTH = 12;
	typedef struct packed {
		logic [15:0] ratio_temp;
		logic [15:0] mono_temp;
		logic [15:0] metal_temp;
		logic [6:0] intensity;
	} pkhc_core_t;
endpackage

/* logic/pkhc_top.sv */
// Peak hold signal conditioner: filter, peak storage, output coding.
// Assumes core values and contact input synchronous to mclk.
`timescale 1ns/1ps
// Summary of operation
// - New sample and output update on each 10 ms measurement tick
// - Double storage: one memory tracks max, other shows last interval
// - Any timed clear setting selects double storage; output from shown memory
// - Smoothing filter runs first; peak stage sees only smoothed values
// - Clear off passes every value straight through
// - Extern: single memory cleared while contact is closed
// - Auto: hold maximum until a new hot object appears
// - Auto clears on rising crossing of lower limit plus 1% or 2 degrees
// - Hold: output frozen while contact closed
// - Live zero range gives 3.9 mA below lower limit
// - Low signal with 21 mA variant drives 21 mA
// - Warning level 0 to 99; zero disables it and frees contact for clearing
// - Relay switches when intensity drops below warning level
// - Switch-off level 2 to 50 percent, default 10
// - Below switch-off report one degree below range start
// - Ratio, single-channel and metal modes; ratio by default
// - Single-channel uses mono temperature; LED lit steadily
// - Metal: LED blinks short dark long lit; needs unity emissivity and slope
// - Sub-range accepted only with span of at least 50 degrees; output scaled to it
// - One sub-range serves ratio and metal modes
module pkhc_top import pkhc_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter logic [15:0] TEMP_MIN = 16'h02bc,
	parameter logic [15:0] TEMP_MAX = 16'h0708
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurement core and contact
	input wire pkhc_core_t core,
	input wire logic ext_contact,
	// Outputs
	output logic [15:0] aout_code,
	output logic relay,
	output logic led
);
	function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? a : b;
	endfunction
	function automatic logic span_ok(input logic [31:0] w, input logic [15:0] mn,
		input logic [15:0] mx);
		return w[15:0] >= mn && w[31:16] <= mx
			&& 17'(w[31:16]) >= 17'(w[15:0]) + 17'(SPAN_MIN);
	endfunction

	// Registers
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [1:0] mode_q;
	logic live0_q, low21_q;
	logic [3:0] clr_q;
	logic [2:0] smooth_q;
	logic [6:0] swoff_q, warn_q;
	logic [9:0] eps_q, slope_q;
	logic [31:0] sub_rm_q, sub_mono_q;
	logic [31:0] filt_q;
	logic [15:0] run_q, show_q, mem_q, disp_q, last_q;
	logic [11:0] ivl_q;
	logic low_q;
	logic [6:0] led_cnt_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, relay_q, led_q;
	logic [15:0] aout_q;

	// Bus decode
	wire setup = psel && !penable;
	wire wr = psel && penable && pready_q && pwrite;
	wire hit_ctrl = paddr == OFF_CTRL;
	wire hit_lvl = paddr == OFF_LEVELS;
	wire hit_emis = paddr == OFF_EMIS;
	wire hit_srm = paddr == OFF_SUB_RM;
	wire hit_smo = paddr == OFF_SUB_MONO;
	wire hit_sta = paddr == OFF_STATUS;
	wire mapped = hit_ctrl | hit_lvl | hit_emis | hit_srm | hit_smo | hit_sta;
	wire bad = !mapped || (pwrite && hit_sta);

	// Write checks; illegal fields keep their old value
	wire [1:0] w_mode = pwdata[F_MODE +: 2];
	wire [3:0] w_clr = pwdata[F_CLR +: 4];
	wire metal_ok = eps_q == UNITY && slope_q == UNITY;
	wire mode_ok = w_mode == MODE_RATIO || w_mode == MODE_MONO
		|| (w_mode == MODE_METAL && metal_ok);
	wire [6:0] w_sw = pwdata[6:0];
	wire [6:0] w_wn = pwdata[14:8];
	wire sw_ok = w_sw >= SWOFF_MIN && w_sw <= SWOFF_MAX;
	wire wn_ok = w_wn <= WARN_MAX;
	wire srm_ok = span_ok(pwdata, TEMP_MIN, TEMP_MAX);
	wire [31:0] ctrl_rd = {16'h0000, 1'b0, smooth_q, clr_q, 2'h0, low21_q, live0_q,
		2'h0, mode_q};
	wire [31:0] sta_rd = {6'h00, relay_q, low_q, 1'b0, core.intensity, disp_q};
	wire [31:0] rd_d = hit_ctrl ? ctrl_rd
		: hit_lvl ? {17'h00000, warn_q, 1'b0, swoff_q}
		: hit_emis ? {6'h00, slope_q, 6'h00, eps_q}
		: hit_srm ? sub_rm_q
		: hit_smo ? sub_mono_q
		: hit_sta ? sta_rd : 32'h00000000;

	// Sample selection and low-signal test
	wire [15:0] raw = (mode_q == MODE_MONO) ? core.mono_temp
		: (mode_q == MODE_METAL) ? core.metal_temp : core.ratio_temp;
	wire low_now = core.intensity < swoff_q;
	wire [15:0] low_val = TEMP_MIN - 16'h0001;

	// First-order low-pass; shift zero passes samples unchanged
	wire [31:0] raw_w = {raw, 16'h0000};
	wire [31:0] filt_d = (smooth_q == 3'h0) ? raw_w
		: filt_q + 32'((signed'(raw_w) - signed'(filt_q)) >>> smooth_q);
	wire [15:0] f = filt_d[31:16];

	// Sub-range shared by ratio and metal modes
	wire [31:0] sub = (mode_q == MODE_MONO) ? sub_mono_q : sub_rm_q;
	wire [15:0] lo = sub[15:0];
	wire [15:0] hi = sub[31:16];
	wire [15:0] step = max16(lo / 16'h0064, AUTO_STEP_MIN);
	wire [15:0] auto_thr = lo + step;
	wire auto_clr = f >= auto_thr && last_q < auto_thr;

	// Contact serves clearing only while the warning is off
	wire contact = ext_contact && warn_q == 7'h00;
	wire timed = clr_q != CLR_OFF && clr_q <= CLR_T_LAST;
	wire ivl_end = timed && ivl_q + 12'h001 >= CLR_TICKS[clr_q];
	wire [15:0] run_max = max16(run_q, f);

	// Displayed value before output coding
	wire [15:0] disp_d = low_q ? low_val
		: timed ? show_q
		: (clr_q == CLR_EXTERN || clr_q == CLR_AUTO) ? mem_q
		: (clr_q == CLR_HOLD && contact) ? disp_q
		: filt_q[31:16];

	// Output coding in microamps
	wire [15:0] span = hi - lo;
	wire [15:0] base = live0_q ? UA_LIVE0 : 16'h0000;
	wire [15:0] full = UA_FULL - base;
	wire [31:0] prod = 32'(disp_q - lo) * 32'(full);
	wire [15:0] frac = 16'(prod / 32'(span));
	wire [15:0] aout_d = (low_q && low21_q) ? UA_LOW21
		: (disp_q < lo) ? (live0_q ? UA_BELOW : 16'h0000)
		: (disp_q >= hi) ? UA_FULL : base + frac;

	// LED pattern for the operating mode
	wire led_d = (mode_q == MODE_MONO) ? 1'b1
		: (mode_q == MODE_METAL) ? (led_cnt_q >= LED_DARK_TICKS)
		: 1'b0;
	wire relay_d = warn_q != 7'h00 && core.intensity < warn_q;

	// Measurement tick
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
			tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h00000000
				: tick_cnt_q + 32'h00000001;
		end
	end

	// APB registers; a zero-wait slave answering in the first access cycle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mode_q <= MODE_RATIO;
			live0_q <= 1'b0;
			low21_q <= 1'b0;
			clr_q <= CLR_OFF;
			smooth_q <= 3'h0;
			swoff_q <= SWOFF_RST;
			warn_q <= 7'h00;
			eps_q <= UNITY;
			slope_q <= UNITY;
			sub_rm_q <= {TEMP_MAX, TEMP_MIN};
			sub_mono_q <= {TEMP_MAX, TEMP_MIN};
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && bad;
			prdata_q <= (setup && !pwrite) ? rd_d : prdata_q;
			if (wr && hit_ctrl) begin
				mode_q <= mode_ok ? w_mode : mode_q;
				clr_q <= (w_clr <= CLR_HOLD) ? w_clr : clr_q;
				live0_q <= pwdata[F_LIVE0];
				low21_q <= pwdata[F_LOW21];
				smooth_q <= pwdata[F_SMOOTH +: 3];
			end
			if (wr && hit_lvl) begin
				swoff_q <= sw_ok ? w_sw : swoff_q;
				warn_q <= wn_ok ? w_wn : warn_q;
			end
			if (wr && hit_emis) begin
				eps_q <= pwdata[9:0];
				slope_q <= pwdata[25:16];
			end
			if (wr && hit_srm && srm_ok) begin
				sub_rm_q <= pwdata;
			end
			if (wr && hit_smo && srm_ok) begin
				sub_mono_q <= pwdata;
			end
		end
	end

	// Filter and peak memories
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			filt_q <= 32'h00000000;
			run_q <= 16'h0000;
			show_q <= 16'h0000;
			mem_q <= 16'h0000;
			last_q <= 16'h0000;
			ivl_q <= 12'h000;
			low_q <= 1'b0;
		end else begin
			if (tick_q) begin
				low_q <= low_now;
				last_q <= f;
				filt_q <= low_now ? {low_val, 16'h0000} : filt_d;
				ivl_q <= ivl_end ? 12'h000 : ivl_q + 12'h001;
				run_q <= ivl_end ? f : run_max;
				show_q <= ivl_end ? run_max : show_q;
				if (clr_q == CLR_AUTO && auto_clr) begin
					mem_q <= f;
				end else begin
					mem_q <= max16(mem_q, f);
				end
			end
			if (!timed) begin
				ivl_q <= 12'h000;
			end
			if (clr_q == CLR_EXTERN && contact) begin
				mem_q <= filt_q[31:16];
			end
		end
	end

	// Outputs
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			disp_q <= 16'h0000;
			aout_q <= 16'h0000;
			relay_q <= 1'b0;
			led_q <= 1'b0;
			led_cnt_q <= 7'h00;
		end else begin
			disp_q <= disp_d;
			aout_q <= aout_d;
			relay_q <= relay_d;
			led_q <= led_d;
			if (tick_q) begin
				led_cnt_q <= (led_cnt_q + 7'h01 >= LED_PERIOD_TICKS) ? 7'h00
					: led_cnt_q + 7'h01;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign aout_code = aout_q;
	assign relay = relay_q;
	assign led = led_q;

	// Checks
	tick_period_a: assert property (@(posedge mclk) disable iff (sys_rst)
		tick_q |=> !tick_q [*2])
		else $error("tick pulses too close");
	pass_through_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clr_q == CLR_OFF && !low_q |=> disp_q == $past(filt_q[31:16]))
		else $error("off mode does not pass value");
	double_show_a: assert property (@(posedge mclk) disable iff (sys_rst)
		timed && !low_q && !$changed(clr_q) |=> disp_q == $past(show_q))
		else $error("display not from shown memory");
	swap_a: assert property (@(posedge mclk) disable iff (sys_rst)
		tick_q && ivl_end |=> show_q == $past(run_max) && ivl_q == 12'h000)
		else $error("memories not swapped");
	ext_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clr_q == CLR_EXTERN && contact && !tick_q |=> mem_q == $past(filt_q[31:16]))
		else $error("external clear missed");
	hold_freeze_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clr_q == CLR_HOLD && contact && !low_q && $stable(clr_q) |=> $stable(disp_q))
		else $error("hold did not freeze");
	low21_out_a: assert property (@(posedge mclk) disable iff (sys_rst)
		low_q && low21_q |=> aout_q == UA_LOW21)
		else $error("low signal code wrong");
	relay_warn_a: assert property (@(posedge mclk) disable iff (sys_rst)
		relay_d |=> relay_q ##0 warn_q != 7'h00 || $past(warn_q) != 7'h00)
		else $error("relay without warning level");
	swoff_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
		swoff_q >= SWOFF_MIN && swoff_q <= SWOFF_MAX)
		else $error("switch-off level out of range");
	sub_span_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sub_rm_q[31:16] >= sub_rm_q[15:0] + SPAN_MIN)
		else $error("sub-range too narrow");
	mono_led_a: assert property (@(posedge mclk) disable iff (sys_rst)
		mode_q == MODE_MONO [*2] |-> led_q)
		else $error("mono led not lit");
	swap_c: cover property (@(posedge mclk) tick_q && ivl_end);
	auto_c: cover property (@(posedge mclk) tick_q && clr_q == CLR_AUTO && auto_clr);
	low_c: cover property (@(posedge mclk) low_q && low21_q);
endmodule

/* test/pkhc_far.sv */
// Far side model: the external contact closure and the analog receiver.
// Assumes the bench commands the contact; the receiver latches each code.
`timescale 1ns/1ps
module pkhc_far (
	// Clock
	input wire logic mclk,
	// Bench command
	input wire logic close_cmd,
	// Device side
	input wire logic [15:0] aout_code,
	output logic ext_contact,
	output logic [15:0] seen_code
);
	// Contact and receiver lag by one cycle; both settle while reset is held
	always @(posedge mclk) begin
		ext_contact <= close_cmd;
		seen_code <= aout_code;
	end
endmodule

/* test/test_pkhc_top.sv */
// Bench for the peak hold conditioner: APB sequences and core stimulus.
// Assumes a shortened tick of 20 cycles and the default 700..1800 range.
`timescale 1ns/1ps
module test_pkhc_top import pkhc_pkg::*;;
	localparam int TK = 20;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pkhc_core_t core = '{16'd1000, 16'd900, 16'd1100, 7'd50};
	logic ext_contact;
	logic close_cmd = 1'b0;
	logic [15:0] aout_code;
	logic [15:0] seen_code;
	logic relay;
	logic led;
	int miscompares = 0;
	int checks_done = 0;
	logic [31:0] r;
	logic e;
	int c;
	int lit;
	always #2.5 mclk = ~mclk;
	pkhc_top #(.TICK_CYCLES(TK)) pkhc_top_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core(core), .ext_contact(ext_contact),
		.aout_code(aout_code), .relay(relay), .led(led));
	pkhc_far pkhc_far_i (.mclk(mclk), .close_cmd(close_cmd), .aout_code(aout_code),
		.ext_contact(ext_contact), .seen_code(seen_code));
	task stop_test;
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// Request held from setup until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		r = prdata;
		e = pslverr;
		if (n >= 40)
			miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task setc(input logic [15:0] t, input logic [6:0] i);
		@(posedge mclk);
		core <= '{t, 16'd900, 16'd1100, i};
	endtask
	task ticks(input int n);
		repeat (n * TK + 6) @(posedge mclk);
	endtask
	// Waits for the next output update, which marks a measurement tick
	task wait_chg;
		logic [15:0] o;
		int n;
		o = aout_code;
		n = 0;
		while (aout_code === o && n < 3 * TK) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 3 * TK)
			miscompares++;
		repeat (4) @(posedge mclk);
	endtask
	task disp_is(input logic [15:0] x);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk({16'h0, r[15:0]}, {16'h0, x});
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, led}, 32'h0);
		apb(1'b0, OFF_LEVELS, 32'h0);
		chk(r, 32'h0000000a);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		ticks(3);
		disp_is(16'd1000);
		chk({16'h0, seen_code}, 32'd5454);
		apb(1'b1, OFF_CTRL, 32'h1000);
		setc(16'd1200, 7'd50);
		wait_chg;
		disp_is(16'd1100);
		wait_chg;
		disp_is(16'd1150);
		for (c = 1; c <= 10; c++) begin
			apb(1'b1, OFF_CTRL, c << 8);
			apb(1'b0, OFF_CTRL, 32'h0);
			chk(r, (c < 10 ? c : 9) << 8);
		end
		apb(1'b1, OFF_CTRL, 32'h0100);
		setc(16'd1300, 7'd50);
		wait_chg;
		setc(16'd900, 7'd50);
		repeat (TK + 4) @(posedge mclk);
		disp_is(16'd1300);
		ticks(3);
		disp_is(16'd900);
		apb(1'b1, OFF_CTRL, 32'h0700);
		setc(16'd1300, 7'd50);
		ticks(2);
		setc(16'd1000, 7'd50);
		ticks(2);
		disp_is(16'd1300);
		close_cmd <= 1'b1;
		ticks(1);
		disp_is(16'd1000);
		close_cmd <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h0900);
		ticks(2);
		close_cmd <= 1'b1;
		setc(16'd1200, 7'd50);
		ticks(2);
		disp_is(16'd1000);
		close_cmd <= 1'b0;
		ticks(2);
		disp_is(16'd1200);
		apb(1'b1, OFF_SUB_RM, {16'd1000, 16'd800});
		apb(1'b1, OFF_SUB_RM, {16'd840, 16'd800});
		apb(1'b0, OFF_SUB_RM, 32'h0);
		chk(r, {16'd1000, 16'd800});
		apb(1'b1, OFF_CTRL, 32'h0010);
		setc(16'd750, 7'd50);
		ticks(2);
		chk({16'h0, seen_code}, {16'h0, UA_BELOW});
		setc(16'd900, 7'd50);
		ticks(2);
		chk({16'h0, seen_code}, 32'd12000);
		apb(1'b1, OFF_CTRL, 32'h0800);
		setc(16'd750, 7'd50);
		ticks(2);
		setc(16'd1300, 7'd50);
		ticks(2);
		setc(16'd1000, 7'd50);
		ticks(2);
		disp_is(16'd1300);
		setc(16'd750, 7'd50);
		ticks(2);
		setc(16'd805, 7'd50);
		ticks(2);
		disp_is(16'd1300);
		setc(16'd900, 7'd50);
		ticks(2);
		disp_is(16'd900);
		apb(1'b1, OFF_CTRL, 32'h0030);
		setc(16'd900, 7'd5);
		ticks(2);
		disp_is(16'd699);
		chk({16'h0, seen_code}, {16'h0, UA_LOW21});
		apb(1'b1, OFF_LEVELS, {17'h0, 7'd30, 1'b0, 7'd10});
		ticks(1);
		chk({31'h0, relay}, 32'h1);
		setc(16'd900, 7'd50);
		ticks(2);
		chk({31'h0, relay}, 32'h0);
		apb(1'b1, OFF_LEVELS, {17'h0, 7'd100, 1'b0, 7'd1});
		apb(1'b0, OFF_LEVELS, 32'h0);
		chk(r, {17'h0, 7'd30, 1'b0, 7'd10});
		apb(1'b1, OFF_EMIS, {6'h0, UNITY, 6'h0, 10'd900});
		apb(1'b1, OFF_CTRL, 32'h2);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(r & 32'h3, 32'h0);
		apb(1'b1, OFF_SUB_MONO, {16'd950, 16'd850});
		apb(1'b1, OFF_CTRL, 32'h1);
		ticks(2);
		disp_is(16'd900);
		chk({31'h0, led}, 32'h1);
		chk({16'h0, seen_code}, 32'd10000);
		apb(1'b1, OFF_EMIS, {6'h0, UNITY, 6'h0, UNITY});
		apb(1'b1, OFF_CTRL, 32'h2);
		ticks(2);
		disp_is(16'd1100);
		chk({16'h0, seen_code}, {16'h0, UA_FULL});
		lit = 0;
		repeat (100 * TK) begin
			@(negedge mclk);
			if (led === 1'b1)
				lit++;
		end
		chk(lit, 80 * TK);
		stop_test;
	end
	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		stop_test;
	end
endmodule
